/* core/flash_host.sv */
// Host controller driving an asynchronous parallel flash from APB registers.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
module flash_host (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Flash pins.
	output logic      [22:0] flash_addr,
	input  wire logic [31:0] flash_dq_in,
	output logic      [31:0] flash_dq_out,
	output logic             flash_dq_oe,
	output logic             flash_ce_n,
	output logic             flash_we_n,
	output logic             flash_oe_n,
	output logic             flash_word_n,
	output logic             flash_reset_n,
	output logic             flash_wp_n,
	input  wire logic        completion_indicator
);
	// ----------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------
	logic [5:0]  ctrl, next_ctrl;       // Control bits, go bit self-clears after the cycle it starts.
	logic [22:0] addr, next_addr;       // Target word address.
	logic [31:0] wdata, next_wdata;     // Data for write cycles.
	logic [31:0] rdata, next_rdata;     // Data of the last read.
	logic        toggled, next_toggled; // Toggle bit changed between reads.
	logic [1:0]  rdy_sync;              // Completion pin synchroniser.
	logic [31:0] dq_sync1, dq_sync2;    // Data input synchroniser.
	flash_host_pkg::bus_state_t state, next_state;
	logic [3:0]  cnt, next_cnt;         // Cycle counter of the strobe phase.
	logic        wr_acc, rd_acc;        // APB access qualifiers.
	logic        sel_n, next_sel_n;     // Registered chip select, active low.
	logic        wstb_n, next_wstb_n;   // Registered write strobe, active low.
	logic        drv_n, next_drv_n;     // Registered output drive, active low.
	logic        dq_en, next_dq_en;     // Registered data drive enable.

	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	// Registers always answer in the first access cycle.
	assign pready  = 1'b1;
	// Unmapped offsets answer with an error.
	assign pslverr = psel && penable && (paddr > flash_host_pkg::off_status || paddr[1:0] != 2'h0);

	// ----------------------------------------------------------------
	// Register and bus cycle next-state logic.
	// ----------------------------------------------------------------
	// Software writes are refused while a cycle runs so the pins never change mid-cycle.
	always_comb begin
		next_ctrl    = ctrl;
		next_addr    = addr;
		next_wdata   = wdata;
		next_rdata   = rdata;
		next_toggled = toggled;
		next_state   = state;
		next_cnt     = cnt;
		if (wr_acc && state == flash_host_pkg::st_idle) begin
			case (paddr)
				flash_host_pkg::off_ctrl:  next_ctrl  = pwdata[5:0];
				flash_host_pkg::off_addr:  next_addr  = pwdata[22:0];
				flash_host_pkg::off_wdata: next_wdata = pwdata;
				default: ;
			endcase
		end
		case (state)
			flash_host_pkg::st_idle: begin
				// A reset hold blocks cycles, since the device ignores them then.
				if (ctrl[flash_host_pkg::ctrl_go_bit] && ctrl[flash_host_pkg::ctrl_reset_bit] == 1'b0) begin
					next_cnt   = 4'h0;
					next_state = ctrl[flash_host_pkg::ctrl_write_bit] ? flash_host_pkg::st_write
						: flash_host_pkg::st_read;
				end
			end
			flash_host_pkg::st_read: begin
				next_cnt = cnt + 4'h1;
				// Two extra cycles cover the data synchroniser.
				if (cnt == 4'(flash_host_pkg::rd_cycles + 2)) begin
					// Narrow mode keeps only the low half.
					next_rdata = ctrl[flash_host_pkg::ctrl_wide_bit] ? dq_sync2 : {16'h0000, dq_sync2[15:0]};
					// Toggle bit compared with previous read.
					next_toggled = dq_sync2[flash_host_pkg::toggle_pos] != rdata[flash_host_pkg::toggle_pos];
					next_state = flash_host_pkg::st_gap;
				end
			end
			flash_host_pkg::st_write: begin
				// Every command word is one strobe of its own, so an unlock bypass program costs two
				// cycles and region entry or exit is a plain series of them issued by software.
				next_cnt = cnt + 4'h1;
				if (cnt == 4'(flash_host_pkg::wr_cycles)) begin
					next_state = flash_host_pkg::st_gap;
				end
			end
			flash_host_pkg::st_gap: begin
				// One idle cycle with all strobes high between cycles.
				next_ctrl[flash_host_pkg::ctrl_go_bit] = 1'b0;
				next_state = flash_host_pkg::st_idle;
			end
			default: next_state = flash_host_pkg::st_idle;
		endcase
	end

	// Register stage for all state but the strobes. The data bus passes two flops like any pin; a read holds
	// select and drive for longer than the access time, so every bit is steady when it is taken
	// and the bus needs no handshake of its own.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= 6'h00;
			addr     <= 23'h000000;
			wdata    <= 32'h00000000;
			rdata    <= 32'h00000000;
			toggled  <= 1'b0;
			state    <= flash_host_pkg::st_idle;
			cnt      <= 4'h0;
			rdy_sync <= 2'h0;
			dq_sync1 <= 32'h00000000;
			dq_sync2 <= 32'h00000000;
		end else begin
			ctrl     <= next_ctrl;
			addr     <= next_addr;
			wdata    <= next_wdata;
			rdata    <= next_rdata;
			toggled  <= next_toggled;
			state    <= next_state;
			cnt      <= next_cnt;
			rdy_sync <= {rdy_sync[0], completion_indicator};
			dq_sync1 <= flash_dq_in;
			dq_sync2 <= dq_sync1;
		end
	end

	// ----------------------------------------------------------------
	// Registered strobe drive.
	// ----------------------------------------------------------------
	// A decode of state and count could glitch low while several bits change at once, and a
	// glitch on the write strobe would latch a stray command, so the strobes come from flops.
	// They are decoded from the next state so each one lines up with the state it belongs to.
	always_comb begin
		// Select covers both kinds of cycle.
		next_sel_n  = !(next_state == flash_host_pkg::st_read || next_state == flash_host_pkg::st_write);
		// Write strobe falls after one setup cycle of address and data.
		next_wstb_n = !(next_state == flash_host_pkg::st_write && next_cnt != 4'h0);
		// Output drive only in reads, so host and device never drive the bus together.
		next_drv_n  = next_state != flash_host_pkg::st_read;
		next_dq_en  = next_state == flash_host_pkg::st_write;
	end

	// Strobes rest high and the data drive stays off while reset is held.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_n  <= 1'h1;
			wstb_n <= 1'h1;
			drv_n  <= 1'h1;
			dq_en  <= 1'h0;
		end else begin
			sel_n  <= next_sel_n;
			wstb_n <= next_wstb_n;
			drv_n  <= next_drv_n;
			dq_en  <= next_dq_en;
		end
	end

	// ----------------------------------------------------------------
	// Read data mux.
	// ----------------------------------------------------------------
	always_comb begin
		prdata = 32'h00000000;
		if (rd_acc) begin
			case (paddr)
				flash_host_pkg::off_ctrl:   prdata = {26'h0, ctrl};
				flash_host_pkg::off_addr:   prdata = {9'h0, addr};
				flash_host_pkg::off_wdata:  prdata = wdata;
				flash_host_pkg::off_rdata:  prdata = rdata;
				flash_host_pkg::off_status: prdata = {28'h0, toggled, rdata[flash_host_pkg::polling_pos],
					rdy_sync[1], state != flash_host_pkg::st_idle};
				default: prdata = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flash pin drive.
	// ----------------------------------------------------------------
	// Separate active-low select, strobe and drive; data only driven on writes.
	assign flash_addr    = addr;
	assign flash_dq_out  = wdata;
	assign flash_dq_oe   = dq_en;
	assign flash_ce_n    = sel_n;
	assign flash_we_n    = wstb_n;
	assign flash_oe_n    = drv_n;
	assign flash_word_n  = ctrl[flash_host_pkg::ctrl_wide_bit];
	assign flash_reset_n = !ctrl[flash_host_pkg::ctrl_reset_bit];
	assign flash_wp_n    = ctrl[flash_host_pkg::ctrl_wp_bit];
endmodule
`default_nettype wire

/* pkg/flash_host_pkg.sv */
// Package with constants shared by the parallel flash host controller.
`default_nettype none
package flash_host_pkg;
	// ----------------------------------------------------------------
	// Register offsets of the controller (byte addresses).
	// ----------------------------------------------------------------
	localparam logic [7:0] off_ctrl   = 8'h00; // Mode and command register.
	localparam logic [7:0] off_addr   = 8'h04; // Flash word address.
	localparam logic [7:0] off_wdata  = 8'h08; // Write data.
	localparam logic [7:0] off_rdata  = 8'h0C; // Last read data.
	localparam logic [7:0] off_status = 8'h10; // Status bits.
	// Control register fields.
	localparam int ctrl_go_bit      = 0; // Start a bus cycle.
	localparam int ctrl_write_bit   = 1; // One for write cycle.
	localparam int ctrl_wide_bit    = 2; // One for 32-bit mode.
	localparam int ctrl_reset_bit   = 3; // Hold flash reset.
	localparam int ctrl_standby_bit = 4; // Stored only; chip select ignores it.
	localparam int ctrl_wp_bit      = 5; // One releases write protect.
	// Status register fields.
	localparam int stat_busy_bit  = 0; // Bus cycle in progress.
	localparam int stat_ready_bit = 1; // Synchronised completion pin.
	localparam int stat_poll_bit  = 2; // Polling status bit of last read.
	localparam int stat_tog_bit   = 3; // Toggle status bit changed.
	// Widths.
	localparam int addr_w = 23; // Word address width.
	localparam int data_w = 32; // Data bus width.
	// Timing in ns and cycles at 100 MHz.
	localparam int clk_ns        = 10;
	localparam int rd_access_ns  = 70; // Random read access.
	localparam int wr_pulse_ns   = 50; // Write strobe low time.
	localparam int rd_cycles     = (rd_access_ns + clk_ns - 1) / clk_ns;
	localparam int wr_cycles     = (wr_pulse_ns + clk_ns - 1) / clk_ns;
	localparam int polling_pos   = 7; // Polling status bit position.
	localparam int toggle_pos    = 6; // Toggle status bit position.
	// Bus cycle states.
	typedef enum logic [3:0] {
		st_idle  = 4'h1,
		st_read  = 4'h2,
		st_write = 4'h4,
		st_gap   = 4'h8
	} bus_state_t;
endpackage
`default_nettype wire

/* test/banked_page_flash_interface_tb.sv */
// Self-checking bench for the bus-driven parallel flash host controller.
`default_nettype none
module banked_page_flash_interface_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dq_oe, ce_n, we_n, oe_n, word_n, rst_n, wp_n, done, want;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, dq_in, dq_out, r, d, d0;
	logic        se, p6; // Error flag of the last access, toggle bit of the last read.
	logic [22:0] faddr;
	logic [63:0] exp_q [$]; // Mask and value of each pending read.
	int          errors = 0;
	int          total_checks = 0;
	flash_host i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.flash_addr(faddr), .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
		.flash_we_n(we_n), .flash_oe_n(oe_n), .flash_word_n(word_n), .flash_reset_n(rst_n), .flash_wp_n(wp_n),
		.completion_indicator(done));
	flash_model i_mem (.addr(faddr), .dq_host(dq_out), .ce_n, .we_n, .oe_n, .word_n, .reset_n(rst_n), .wp_n,
		.dq(dq_in), .done);
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	// Single compare point for every check of the bench.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
		total_checks++;
		if (seen !== expv) begin
			errors++;
			$display("BAD %s exp %h seen %h", what, expv, seen);
		end
	endtask
	// Watcher takes the oldest note whenever a checked read is answered.
	always @(posedge pclk) if (psel && penable && pready && want) begin
		check("prdata", prdata & exp_q[0][63:32], exp_q[0][31:0]);
		void'(exp_q.pop_front());
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [63:0] e, input logic c);
		@(posedge pclk);
		psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= wd; want <= c;
		if (c) exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		se = pslverr;
		psel <= 1'h0; penable <= 1'h0; want <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0, {m, e}, 1'h1);
	endtask
	// One flash cycle, then status is polled until the controller is idle.
	task automatic op(input logic w, input logic [22:0] a, input logic [31:0] wd, input logic wide,
		input logic wp = 1'h1);
		apb(1'h1, 8'h04, {9'h000, a}, 64'h0, 1'h0);
		apb(1'h1, 8'h08, wd, 64'h0, 1'h0);
		apb(1'h1, 8'h00, {26'h0, wp, 2'h0, wide, w, 1'h1}, 64'h0, 1'h0);
		r = 32'h1;
		while (r[0] !== 1'h0) apb(1'h0, 8'h10, 32'h0, 64'h0, 1'h0);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00; pwdata = 32'h0; want = 1'h0;
		void'($urandom(32'h0139));
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		rd(8'h00, 32'hFFFFFFFF, 32'h0);
		rd(8'h0C, 32'hFFFFFFFF, 32'h0);
		p6 = 1'h0;
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			if (i == 0) d0 = d;
			op(1'h1, 23'(i), d, 1'h1);
			op(1'h0, 23'(i), 32'h0, 1'h1);
			rd(8'h0C, 32'hFFFFFFFF, d);
			rd(8'h10, 32'hC, {28'h0, d[6] ^ p6, d[7], 2'h0});
			p6 = d[6];
		end
		$display("test wide transfers done");
		check("flash_wp_n", {31'h0, wp_n}, 32'h1);
		op(1'h1, 23'h0, ~d0, 1'h1, 1'h0);
		@(negedge pclk);
		check("flash_wp_n", {31'h0, wp_n}, 32'h0);
		op(1'h0, 23'h0, 32'h0, 1'h1);
		rd(8'h0C, 32'hFFFFFFFF, d0);
		$display("test write protect done");
		d = $urandom;
		op(1'h1, 23'h5, d, 1'h0);
		rd(8'h10, 32'h2, 32'h0);
		repeat (30) @(posedge pclk);
		rd(8'h10, 32'h2, 32'h2);
		op(1'h0, 23'h5, 32'h0, 1'h0);
		rd(8'h0C, 32'hFFFFFFFF, {16'h0, d[15:0]});
		apb(1'h1, 8'h0C, 32'hFFFFFFFF, 64'h0, 1'h0);
		apb(1'h0, 8'h14, 32'h0, 64'h0, 1'h0);
		check("pslverr", {31'h0, se}, 32'h1);
		rd(8'h0C, 32'hFFFFFFFF, {16'h0, d[15:0]});
		check("pslverr", {31'h0, se}, 32'h0);
		$display("test narrow and completion done");
		apb(1'h1, 8'h00, 32'h8, 64'h0, 1'h0);
		@(negedge pclk);
		check("flash_reset_n", {31'h0, rst_n}, 32'h0);
		rd(8'h00, 32'h8, 32'h8);
		apb(1'h1, 8'h00, 32'h9, 64'h0, 1'h0);
		repeat (20) @(posedge pclk);
		rd(8'h10, 32'h1, 32'h0);
		apb(1'h1, 8'h00, 32'h0, 64'h0, 1'h0);
		@(negedge pclk);
		check("flash_reset_n", {31'h0, rst_n}, 32'h1);
		$display("test flash reset done");
		give_verdict();
	end
	initial begin
		#200us;
		errors++;
		give_verdict();
	end
endmodule
bind flash_host flash_host_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_word_n, .flash_reset_n);
`default_nettype wire

/* test/flash_host_assertions.sv */
// Concurrent checks on the flash host controller's ports.
`default_nettype none
module flash_host_assertions (
	// Clock, reset and bus.
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	// Flash controls.
	input wire logic       flash_dq_oe,
	input wire logic       flash_ce_n,
	input wire logic       flash_we_n,
	input wire logic       flash_oe_n,
	input wire logic       flash_word_n,
	input wire logic       flash_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic ctrl_wr; // Only a control write may move the mode pins.
	assign ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
	a_strobes_apart: assert property (flash_we_n || flash_oe_n)
		else $error("write strobe and output drive low together");
	a_write_framed: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
		else $error("write strobe without select or data drive");
	a_read_undriven: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
		else $error("host drives data during a read");
	a_write_pulse: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
		else $error("write strobe low time wrong");
	a_width_hold: assert property (!ctrl_wr |=> $stable(flash_word_n))
		else $error("width select moved without control write");
	a_reset_hold: assert property (!ctrl_wr |=> $stable(flash_reset_n))
		else $error("flash reset moved without control write");
	a_no_cycle_rst: assert property (!flash_reset_n |-> flash_ce_n)
		else $error("cycle started while flash held in reset");
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("bus access not answered at once");
	a_bad_offset: assert property (psel && penable && (paddr > 8'h10 || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("bad offset not flagged");
endmodule
`default_nettype wire

/* test/flash_model.sv */
// Behavioural parallel flash facing the host controller's pins.
`default_nettype none
module flash_model (
	// Flash pins.
	input  wire logic [22:0] addr,
	input  wire logic [31:0] dq_host,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        word_n,
	input  wire logic        reset_n,
	input  wire logic        wp_n,
	output logic      [31:0] dq,
	output logic             done
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int guard_bits = 12;   // Address bits spanned by the outer guarded sectors; a plain default.
	logic [31:0] mem [0:15];          // Small array; upper address bits fold away.
	logic        armed = 1'h0;        // A write strobe went low inside a select.
	logic        strobe_n;            // Write ends when strobe or select rises first.
	logic        guarded;             // Address lies in an outer boot sector.
	assign strobe_n = we_n || ce_n;
	assign guarded  = addr[22:guard_bits] == '0 || addr[22:guard_bits] == '1;
	always @(negedge strobe_n) armed = 1'h1;
	logic [31:0] junk = 32'hA5A55A5A; // Released lines flip so stale data cannot pass.
	initial done = 1'h1;
	always #5 junk = ~junk;
	// Strobe release latches address and data, then a busy period follows.
	// Select and strobe may rise in the same step, so the first rising of either ends the write.
	always @(posedge strobe_n) if (armed && reset_n) begin
		armed = 1'h0;
		// Write protect low refuses the outer sectors whatever else is set.
		if (wp_n || !guarded) begin
			mem[addr[3:0]] <= word_n ? dq_host : {16'h0000, dq_host[15:0]};
			done <= 1'h0;
			done <= #200 1'h1;
		end
	end
	always @(negedge reset_n) done <= 1'h1;
	// Any location answers at once, also while a write is still busy, so reads never stall.
	assign dq = (ce_n || oe_n) ? junk : word_n ? mem[addr[3:0]] : {junk[31:16], mem[addr[3:0]][15:0]};
endmodule
`default_nettype wire
